// ==== core/pwmc_pkg.sv ====
// PWM control package: offsets, fields, carriers.
// Assumes a byte-addressed register port with 32-bit data.
`default_nettype none
package pwmc_pkg;
   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_MASTER_CTL  = 8'h00;
   localparam logic [7:0] OFS_CNT_SYNC    = 8'h04;
   localparam logic [7:0] OFS_OUT_EN      = 8'h08;
   localparam logic [7:0] OFS_OUT_INV     = 8'h0c;
   localparam logic [7:0] OFS_OUT_FAULT   = 8'h10;
   localparam logic [7:0] OFS_MOD_IRQ_EN  = 8'h14;
   localparam logic [7:0] OFS_MOD_IRQ_RAW = 8'h18;
   localparam logic [7:0] OFS_MOD_IRQ_ISC = 8'h1c;
   localparam logic [7:0] OFS_FAULT_LVL   = 8'h20;
   localparam logic [7:0] OFS_GEN_CTL     = 8'h40;
   localparam logic [7:0] OFS_GEN_IRQ_EN  = 8'h44;
   localparam logic [7:0] OFS_GEN_IRQ_RAW = 8'h48;
   localparam logic [7:0] OFS_GEN_IRQ_ISC = 8'h4c;
   localparam logic [7:0] OFS_GEN_LOAD    = 8'h50;
   localparam logic [7:0] OFS_GEN_COUNT   = 8'h54;
   localparam logic [7:0] OFS_GEN_CMPA    = 8'h58;
   localparam logic [7:0] OFS_GEN_CMPB    = 8'h5c;
   localparam logic [7:0] OFS_GEN_ACT_A   = 8'h60;
   localparam logic [7:0] OFS_GEN_ACT_B   = 8'h64;
   localparam logic [7:0] OFS_DB_CTL      = 8'h68;
   localparam logic [7:0] OFS_DB_RISE     = 8'h6c;
   localparam logic [7:0] OFS_DB_FALL     = 8'h70;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CTL_RUN_BIT      = 0;   // gen_control: counter runs
   localparam int CTL_UPDOWN_BIT   = 1;   // gen_control: up/down mode
   localparam int CTL_DBG_RUN_BIT  = 2;   // gen_control: keep running on stall
   localparam int CTL_LOAD_SYN_BIT = 3;   // gen_control: load waits for global update
   localparam int CTL_CMP_SYN_BIT  = 4;   // gen_control: compares wait for global update
   localparam int GEN_CTL_W        = 5;
   localparam int MOD_IRQ_GEN_BIT  = 0;
   localparam int MOD_IRQ_FLT_BIT  = 16;
   localparam int EVT_W            = 6;   // zero, load, a_up, a_dn, b_up, b_dn
   localparam int ACT_W            = 12;  // two bits per event
   localparam int NUM_OUT          = 2;

   // ----------------------------------------------------------------
   // Reset values and action codes
   // ----------------------------------------------------------------
   localparam logic [31:0] REG_RESET  = 32'h0000_0000;
   localparam logic [1:0]  ACT_NONE   = 2'h0;
   localparam logic [1:0]  ACT_TOGGLE = 2'h1;
   localparam logic [1:0]  ACT_LOW    = 2'h2;
   localparam logic [1:0]  ACT_HIGH   = 2'h3;

   // Counter direction
   typedef enum logic {
      PWMC_DIR_DOWN = 1'b0,
      PWMC_DIR_UP   = 1'b1
   } pwmc_dir_t;

   // Raw counter events, in irq enable and action bit order
   typedef struct packed {
      logic b_dn;
      logic b_up;
      logic a_dn;
      logic a_up;
      logic load;
      logic zero;
   } pwmc_evt_t;

   // Register bus request
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } pwmc_req_t;
endpackage
`default_nettype wire

// ==== core/pwmc_top.sv ====
// PWM module: one generator with control, fault and output stage.
// Assumes one 125 MHz clock, a plain register port, asynchronous fault and stall pins.
//
// Local design decision: strobed register access.
`default_nettype none

// Notes on behaviour
// - Any subset of counter events raises interrupts
// - Interrupts use raw events, not dead-band edges
// - Sync control resets the generator counter
// - Immediate updates apply at next counter zero
// - Synchronous updates wait for global request
// - Pending updates switch over together
// - Fault pin and debug stall are faults
// - Per-output force low on fault
// - Fault can raise a processor interrupt
// - Stall: keep running or halt at zero
// - Debug stall never raises an interrupt
// - Output enable gates pins, not generator
// - Per-output inversion is last step
// - Control bit 0 starts counter
// - Status bits clear on write one
// - Status register shows fault input level
// - Separate rising and falling dead-band delays
// - Registers at listed offsets, reset zero
// - Global update bit self-clears, software cannot
// - Counter sync bit self-clears when done
// - Disabled output is zero, still inverted
// - Fault forcing precedes inverter
module pwmc_top
   import pwmc_pkg::*;
#(
   parameter int CNT_W = 16,
   parameter int DB_W  = 12
) (
   // Clock and reset
   input  wire logic              i_mclk,
   input  wire logic              i_rst_n,
   // Register port
   input  wire logic [7:0]        i_addr,
   input  wire logic [31:0]       i_wdata,
   input  wire logic              i_wr,
   input  wire logic              i_rd,
   output logic      [31:0]       o_rdata,
   // Pins and debug
   input  wire logic              i_fault_pin,
   input  wire logic              i_dbg_stall,
   output logic      [NUM_OUT-1:0] o_pwm_pin,
   output logic                   o_irq
);
   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   pwmc_req_t            req;
   logic [2:0]           flt_sync, dbg_sync;
   logic                 fault_lvl, next_fault_lvl, dbg_lvl, next_dbg_lvl;
   logic                 global_upd, next_global_upd;
   logic                 cnt_sync, next_cnt_sync;
   logic [NUM_OUT-1:0]   out_en, next_out_en, out_inv, next_out_inv, out_force, next_out_force;
   logic                 mirq_gen_en, next_mirq_gen_en, mirq_flt_en, next_mirq_flt_en;
   logic                 flt_latch, next_flt_latch;
   logic [GEN_CTL_W-1:0] gen_ctl, next_gen_ctl;
   logic [EVT_W-1:0]     girq_en, next_girq_en, girq_raw, next_girq_raw;
   logic [CNT_W-1:0]     load_sh, next_load_sh, cmpa_sh, next_cmpa_sh, cmpb_sh, next_cmpb_sh;
   logic [CNT_W-1:0]     load_act, next_load_act, cmpa_act, next_cmpa_act, cmpb_act, next_cmpb_act;
   logic [ACT_W-1:0]     act_a, next_act_a, act_b, next_act_b;
   logic                 db_en, next_db_en;
   logic [DB_W-1:0]      db_rise, next_db_rise, db_fall, next_db_fall;
   logic [31:0]          rdata, next_rdata;
   logic [CNT_W-1:0]     cnt, next_cnt;
   pwmc_dir_t            dir, next_dir;
   pwmc_evt_t            evt;
   logic                 running, at_zero, upd_load, upd_cmp;
   logic [1:0]           wave, next_wave;
   logic [1:0]           db_in, db_out;
   logic [DB_W-1:0]      db_cnt [2];
   logic [DB_W-1:0]      next_db_cnt [2];
   logic [DB_W-1:0]      db_lim [2];
   logic [NUM_OUT-1:0]   pin, next_pin, gen_out;
   logic                 gen_isc_any, mod_isc_gen, mod_isc_flt;

   assign req = '{wr: i_wr, rd: i_rd, addr: i_addr, wdata: i_wdata};

   // Write decode for every register
   function automatic logic wr_hit(input pwmc_req_t r, input logic [7:0] ofs);
      wr_hit = r.wr && (r.addr == ofs);
   endfunction

   // Apply one two-bit action to a wave level
   function automatic logic apply_act(input logic lvl, input logic [1:0] act);
      case (act)
         ACT_TOGGLE: apply_act = ~lvl;
         ACT_LOW:    apply_act = 1'b0;
         ACT_HIGH:   apply_act = 1'b1;
         default:    apply_act = lvl;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   // Three stages; a level counts once stages two and three agree
   always_comb begin
      next_fault_lvl = (flt_sync[1] == flt_sync[2]) ? flt_sync[2] : fault_lvl;
      next_dbg_lvl   = (dbg_sync[1] == dbg_sync[2]) ? dbg_sync[2] : dbg_lvl;
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         flt_sync  <= 3'h0;
         dbg_sync  <= 3'h0;
         fault_lvl <= 1'b0;
         dbg_lvl   <= 1'b0;
      end else begin
         flt_sync  <= {flt_sync[1:0], i_fault_pin};
         dbg_sync  <= {dbg_sync[1:0], i_dbg_stall};
         fault_lvl <= next_fault_lvl;
         dbg_lvl   <= next_dbg_lvl;
      end
   end

   // ----------------------------------------------------------------
   // Counter and events
   // ----------------------------------------------------------------
   // stall halt at zero
   assign running = gen_ctl[CTL_RUN_BIT] &&
                    !(dbg_lvl && !gen_ctl[CTL_DBG_RUN_BIT] && cnt == '0);
   assign at_zero = (cnt == '0);

   // Raw events; compares masked by zero or load
   always_comb begin
      evt      = '0;
      evt.zero = running && at_zero;
      evt.load = running && (cnt == load_act);
      if (running && !evt.zero && !evt.load) begin
         evt.a_up = (cnt == cmpa_act) && (dir == PWMC_DIR_UP);
         evt.a_dn = (cnt == cmpa_act) && (dir == PWMC_DIR_DOWN);
         evt.b_up = (cnt == cmpb_act) && (dir == PWMC_DIR_UP);
         evt.b_dn = (cnt == cmpb_act) && (dir == PWMC_DIR_DOWN);
      end
   end

   // Next count: down mode wraps to load, up/down turns at ends
   always_comb begin
      next_cnt = cnt;
      next_dir = dir;
      if (cnt_sync || !gen_ctl[CTL_RUN_BIT]) begin
         next_cnt = '0;
         next_dir = gen_ctl[CTL_UPDOWN_BIT] ? PWMC_DIR_UP : PWMC_DIR_DOWN;
      end else if (running) begin
         if (!gen_ctl[CTL_UPDOWN_BIT]) begin
            next_dir = PWMC_DIR_DOWN;
            next_cnt = at_zero ? load_act : cnt - 1'b1;
         end else if (dir == PWMC_DIR_UP) begin
            if (cnt >= load_act) begin
               next_dir = PWMC_DIR_DOWN;
               next_cnt = at_zero ? cnt : cnt - 1'b1;
            end else begin
               next_cnt = cnt + 1'b1;
            end
         end else begin
            if (at_zero) begin
               next_dir = PWMC_DIR_UP;
               next_cnt = (load_act != '0) ? cnt + 1'b1 : cnt;
            end else begin
               next_cnt = cnt - 1'b1;
            end
         end
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt <= '0;
         dir <= PWMC_DIR_DOWN;
      end else begin
         cnt <= next_cnt;
         dir <= next_dir;
      end
   end

   // ----------------------------------------------------------------
   // Wave generator and dead band
   // ----------------------------------------------------------------
   // Each wave applies its own action per event, in bit order
   always_comb begin
      next_wave = wave;
      for (int e = 0; e < EVT_W; e++) begin
         if (evt[e]) begin
            next_wave[0] = apply_act(next_wave[0], act_a[2*e +: 2]);
            next_wave[1] = apply_act(next_wave[1], act_b[2*e +: 2]);
         end
      end
   end

   assign db_in  = {~wave[0], wave[0]};
   assign db_lim[0] = db_rise;
   assign db_lim[1] = db_fall;

   // Delay each rising edge by its own count
   for (genvar g = 0; g < 2; g++) begin : g_db
      always_comb begin
         next_db_cnt[g] = '0;
         if (db_in[g]) begin
            next_db_cnt[g] = (db_cnt[g] < db_lim[g]) ? db_cnt[g] + 1'b1 : db_cnt[g];
         end
      end
      assign db_out[g] = db_in[g] && (db_cnt[g] >= db_lim[g]);
   end

   assign gen_out = db_en ? db_out : wave;

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wave   <= 2'h0;
         db_cnt <= '{default: '0};
      end else begin
         wave   <= next_wave;
         db_cnt <= next_db_cnt;
      end
   end

   // ----------------------------------------------------------------
   // Output conditioning
   // ----------------------------------------------------------------
   // enable, fault force, invert, register
   always_comb begin
      for (int i = 0; i < NUM_OUT; i++) begin
         next_pin[i] = gen_out[i] & out_en[i];
         // faults and force low and before inverter
         if (out_force[i] && (fault_lvl || dbg_lvl)) next_pin[i] = 1'b0;
         next_pin[i] = next_pin[i] ^ out_inv[i];
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pin <= '0;
      end else begin
         pin <= next_pin;
      end
   end
   assign o_pwm_pin = pin;

   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------
   assign gen_isc_any = |(girq_raw & girq_en);
   assign mod_isc_gen = gen_isc_any & mirq_gen_en;
   assign mod_isc_flt = flt_latch & mirq_flt_en;
   // sync mode waits for global request and switch together
   assign upd_load = at_zero && (!gen_ctl[CTL_LOAD_SYN_BIT] || global_upd);
   assign upd_cmp  = at_zero && (!gen_ctl[CTL_CMP_SYN_BIT] || global_upd);

   always_comb begin
      next_global_upd  = global_upd;
      next_cnt_sync    = 1'b0;
      next_out_en      = out_en;
      next_out_inv     = out_inv;
      next_out_force   = out_force;
      next_mirq_gen_en = mirq_gen_en;
      next_mirq_flt_en = mirq_flt_en;
      next_flt_latch   = flt_latch;
      next_gen_ctl     = gen_ctl;
      next_girq_en     = girq_en;
      next_girq_raw    = girq_raw;
      next_load_sh     = load_sh;
      next_cmpa_sh     = cmpa_sh;
      next_cmpb_sh     = cmpb_sh;
      next_load_act    = load_act;
      next_cmpa_act    = cmpa_act;
      next_cmpb_act    = cmpb_act;
      next_act_a       = act_a;
      next_act_b       = act_b;
      next_db_en       = db_en;
      next_db_rise     = db_rise;
      next_db_fall     = db_fall;
      next_rdata       = 32'h0;
      // set only by software, cleared by hardware at zero
      if (global_upd && at_zero) next_global_upd = 1'b0;
      if (wr_hit(req, OFS_MASTER_CTL) && req.wdata[0]) next_global_upd = 1'b1;
      // sync bit set for one cycle, cleared after reset
      if (wr_hit(req, OFS_CNT_SYNC)) next_cnt_sync = req.wdata[0];
      if (wr_hit(req, OFS_OUT_EN)) next_out_en = req.wdata[NUM_OUT-1:0];
      if (wr_hit(req, OFS_OUT_INV)) next_out_inv = req.wdata[NUM_OUT-1:0];
      if (wr_hit(req, OFS_OUT_FAULT)) next_out_force = req.wdata[NUM_OUT-1:0];
      if (wr_hit(req, OFS_MOD_IRQ_EN)) begin
         next_mirq_gen_en = req.wdata[MOD_IRQ_GEN_BIT];
         next_mirq_flt_en = req.wdata[MOD_IRQ_FLT_BIT];
      end
      // write one clears fault latch; set wins
      if (wr_hit(req, OFS_MOD_IRQ_ISC) && req.wdata[MOD_IRQ_FLT_BIT]) next_flt_latch = 1'b0;
      // latch fault pin rise and stall not latched
      if (next_fault_lvl && !fault_lvl) next_flt_latch = 1'b1;
      if (wr_hit(req, OFS_GEN_CTL)) next_gen_ctl = req.wdata[GEN_CTL_W-1:0];
      if (wr_hit(req, OFS_GEN_IRQ_EN)) next_girq_en = req.wdata[EVT_W-1:0];
      if (wr_hit(req, OFS_GEN_IRQ_ISC)) next_girq_raw = girq_raw & ~req.wdata[EVT_W-1:0];
      // all raw events, enabled or not; set wins
      next_girq_raw = next_girq_raw | evt;
      // load holds period minus one in down mode, as written
      if (wr_hit(req, OFS_GEN_LOAD)) next_load_sh = req.wdata[CNT_W-1:0];
      if (wr_hit(req, OFS_GEN_CMPA)) next_cmpa_sh = req.wdata[CNT_W-1:0];
      if (wr_hit(req, OFS_GEN_CMPB)) next_cmpb_sh = req.wdata[CNT_W-1:0];
      if (wr_hit(req, OFS_GEN_ACT_A)) next_act_a = req.wdata[ACT_W-1:0];
      if (wr_hit(req, OFS_GEN_ACT_B)) next_act_b = req.wdata[ACT_W-1:0];
      if (wr_hit(req, OFS_DB_CTL)) next_db_en = req.wdata[0];
      if (wr_hit(req, OFS_DB_RISE)) next_db_rise = req.wdata[DB_W-1:0];
      if (wr_hit(req, OFS_DB_FALL)) next_db_fall = req.wdata[DB_W-1:0];
      if (upd_load) next_load_act = load_sh;
      if (upd_cmp) begin
         next_cmpa_act = cmpa_sh;
         next_cmpb_act = cmpb_sh;
      end
      if (req.rd) begin
         case (req.addr)
            OFS_MASTER_CTL:  next_rdata = {31'h0, global_upd};
            OFS_CNT_SYNC:    next_rdata = {31'h0, cnt_sync};
            OFS_OUT_EN:      next_rdata = {30'h0, out_en};
            OFS_OUT_INV:     next_rdata = {30'h0, out_inv};
            OFS_OUT_FAULT:   next_rdata = {30'h0, out_force};
            OFS_MOD_IRQ_EN:  next_rdata = {15'h0, mirq_flt_en, 15'h0, mirq_gen_en};
            OFS_MOD_IRQ_RAW: next_rdata = {15'h0, flt_latch, 15'h0, gen_isc_any};
            OFS_MOD_IRQ_ISC: next_rdata = {15'h0, mod_isc_flt, 15'h0, mod_isc_gen};
            OFS_FAULT_LVL:   next_rdata = {31'h0, fault_lvl};
            OFS_GEN_CTL:     next_rdata = {27'h0, gen_ctl};
            OFS_GEN_IRQ_EN:  next_rdata = {26'h0, girq_en};
            OFS_GEN_IRQ_RAW: next_rdata = {26'h0, girq_raw};
            OFS_GEN_IRQ_ISC: next_rdata = {26'h0, girq_raw & girq_en};
            OFS_GEN_LOAD:    next_rdata = 32'(load_sh);
            OFS_GEN_COUNT:   next_rdata = 32'(cnt);
            OFS_GEN_CMPA:    next_rdata = 32'(cmpa_sh);
            OFS_GEN_CMPB:    next_rdata = 32'(cmpb_sh);
            OFS_GEN_ACT_A:   next_rdata = 32'(act_a);
            OFS_GEN_ACT_B:   next_rdata = 32'(act_b);
            OFS_DB_CTL:      next_rdata = {31'h0, db_en};
            OFS_DB_RISE:     next_rdata = 32'(db_rise);
            OFS_DB_FALL:     next_rdata = 32'(db_fall);
            default:         next_rdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         global_upd  <= 1'b0;
         cnt_sync    <= 1'b0;
         out_en      <= '0;
         out_inv     <= '0;
         out_force   <= '0;
         mirq_gen_en <= 1'b0;
         mirq_flt_en <= 1'b0;
         flt_latch   <= 1'b0;
         gen_ctl     <= '0;
         girq_en     <= '0;
         girq_raw    <= '0;
         load_sh     <= '0;
         cmpa_sh     <= '0;
         cmpb_sh     <= '0;
         load_act    <= '0;
         cmpa_act    <= '0;
         cmpb_act    <= '0;
         act_a       <= '0;
         act_b       <= '0;
         db_en       <= 1'b0;
         db_rise     <= '0;
         db_fall     <= '0;
         rdata       <= REG_RESET;
         o_irq       <= 1'b0;
      end else begin
         global_upd  <= next_global_upd;
         cnt_sync    <= next_cnt_sync;
         out_en      <= next_out_en;
         out_inv     <= next_out_inv;
         out_force   <= next_out_force;
         mirq_gen_en <= next_mirq_gen_en;
         mirq_flt_en <= next_mirq_flt_en;
         flt_latch   <= next_flt_latch;
         gen_ctl     <= next_gen_ctl;
         girq_en     <= next_girq_en;
         girq_raw    <= next_girq_raw;
         load_sh     <= next_load_sh;
         cmpa_sh     <= next_cmpa_sh;
         cmpb_sh     <= next_cmpb_sh;
         load_act    <= next_load_act;
         cmpa_act    <= next_cmpa_act;
         cmpb_act    <= next_cmpb_act;
         act_a       <= next_act_a;
         act_b       <= next_act_b;
         db_en       <= next_db_en;
         db_rise     <= next_db_rise;
         db_fall     <= next_db_fall;
         rdata       <= next_rdata;
         o_irq       <= mod_isc_gen | mod_isc_flt;
      end
   end
   assign o_rdata = rdata;
endmodule
`default_nettype wire

// ==== dv/pwmc_top_assertions.sv ====
// Checker on pwmc_top ports: register port, pins, interrupt.
// Assumes the bench idles a cycle after each write.
`default_nettype none
module pwmc_checker
   import pwmc_pkg::*;
#(
   parameter int DB_W = 12
) (
   // Clock, reset and register port
   input  wire logic               i_mclk,
   input  wire logic               i_rst_n,
   input  wire logic [7:0]         i_addr,
   input  wire logic [31:0]        i_wdata,
   input  wire logic               i_wr,
   input  wire logic               i_rd,
   input  wire logic [31:0]        o_rdata,
   // Pins and interrupt
   input  wire logic               i_fault_pin,
   input  wire logic               i_dbg_stall,
   input  wire logic [NUM_OUT-1:0] o_pwm_pin,
   input  wire logic               o_irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);
   logic [1:0] en, inv, frc, men;
   logic [3:0] cfg_age, flt_age;
   wire        cfg_wr = i_wr && (i_addr inside {OFS_OUT_EN, OFS_OUT_INV, OFS_OUT_FAULT});
   wire  [1:0] gate   = ~en | (frc & {2{i_fault_pin | i_dbg_stall}});
   // Shadow of output and interrupt controls, settle ages
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         {en, inv, frc, men, cfg_age, flt_age} <= '0;
      end else begin
         if (i_wr && i_addr == OFS_OUT_EN) en <= i_wdata[1:0];
         if (i_wr && i_addr == OFS_OUT_INV) inv <= i_wdata[1:0];
         if (i_wr && i_addr == OFS_OUT_FAULT) frc <= i_wdata[1:0];
         if (i_wr && i_addr == OFS_MOD_IRQ_EN) men <= {i_wdata[16], i_wdata[0]};
         cfg_age <= cfg_wr ? 4'h0 : cfg_age + {3'h0, cfg_age != 4'hf};
         flt_age <= ($changed(i_fault_pin) || $changed(i_dbg_stall)) ? 4'h0 : flt_age + {3'h0, flt_age != 4'hf};
      end
   end
   sequence s_fault_up; $rose(i_fault_pin) && men[1] ##1 (i_fault_pin && men[1])[*4]; endsequence
   sequence s_sync_wr; i_wr && i_addr == OFS_CNT_SYNC && i_wdata[0]; endsequence
   property p_gate; cfg_age > 4'h2 && flt_age > 4'h5 |-> (o_pwm_pin & gate) == (inv & gate); endproperty
   property p_rd_idle; !i_rd |=> o_rdata == 32'h0; endproperty
   property p_unmapped; i_rd && (i_addr inside {8'h24, 8'h3c, 8'h74}) |=> o_rdata == 32'h0; endproperty
   property p_fault_lvl; i_rd && i_addr == OFS_FAULT_LVL && flt_age > 4'h5 |=> o_rdata == {31'h0, $past(i_fault_pin)}; endproperty
   property p_fault_irq; s_fault_up |-> ##[0:2] o_irq; endproperty
   property p_no_irq; men == 2'h0 && $past(men) == 2'h0 && $past(men, 2) == 2'h0 |-> !o_irq; endproperty
   property p_sync_clr; s_sync_wr ##1 !(i_wr && i_addr == OFS_CNT_SYNC) [*3] ##1 (i_rd && i_addr == OFS_CNT_SYNC) |=> !o_rdata[0]; endproperty
   property p_en_rb; i_wr && i_addr == OFS_OUT_EN ##1 !i_wr ##1 (i_rd && i_addr == OFS_OUT_EN) |=> o_rdata == ($past(i_wdata, 3) & 32'h3); endproperty
   property p_rise_rb; i_wr && i_addr == OFS_DB_RISE ##1 !i_wr ##1 (i_rd && i_addr == OFS_DB_RISE) |=> o_rdata == ($past(i_wdata, 3) & ((32'h1 << DB_W) - 32'h1)); endproperty
   property p_w1c; i_wr && i_addr == OFS_MOD_IRQ_ISC && i_wdata[16] && flt_age > 4'h5 && !i_fault_pin ##1 !i_fault_pin ##1 (i_rd && i_addr == OFS_MOD_IRQ_RAW) |=> !o_rdata[16]; endproperty
   a_gate: assert property (p_gate) else $error("pin not at idle level");
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   a_fault_lvl: assert property (p_fault_lvl) else $error("fault level read wrong");
   a_fault_irq: assert property (p_fault_irq) else $error("fault interrupt missing");
   a_no_irq: assert property (p_no_irq) else $error("interrupt while disabled");
   a_sync_clr: assert property (p_sync_clr) else $error("counter sync bit stuck");
   a_en_rb: assert property (p_en_rb) else $error("output enable readback wrong");
   a_rise_rb: assert property (p_rise_rb) else $error("rise delay readback wrong");
   a_w1c: assert property (p_w1c) else $error("fault status not cleared");
endmodule
bind pwmc_top pwmc_checker #(.DB_W(DB_W)) u_pwmc_checker (.i_mclk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd,
   .o_rdata, .i_fault_pin, .i_dbg_stall, .o_pwm_pin, .o_irq);
`default_nettype wire

// ==== dv/pwmc_drv_model.sv ====
// Driver stage on both pins: reports a trip, counts gate zero rises.
// Assumes gates are the registered pin levels.
`default_nettype none
module pwmc_drv_model (
   // Clock, reset and gates
   input  wire logic       i_mclk,
   input  wire logic       i_rst_n,
   input  wire logic [1:0] i_gate,
   input  wire logic       i_trip,
   input  wire logic       i_clr,
   // Fault report and edge count
   output logic            o_fault,
   output logic [7:0]      o_edges
);
   timeunit 1ns;
   timeprecision 1ps;
   logic g0_q;
   // Trip one cycle late; count gate zero rises
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         {o_fault, g0_q, o_edges} <= '0;
      end else begin
         o_fault <= i_trip;
         g0_q <= i_gate[0];
         o_edges <= i_clr ? 8'h0 : o_edges + {7'h0, i_gate[0] & ~g0_q};
      end
   end
endmodule
`default_nettype wire

// ==== dv/tb_pwmc_top.sv ====
// Bench for pwmc_top: registers, updates, fault, stall, outputs.
// Assumes the checker binds itself and the driver model sits on the pins.
`default_nettype none
module tb_pwmc_top
   import pwmc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk, rst_n, wr, rd, stall, trip, clr, fault, irq;
   logic [7:0]  addr, edges;
   logic [31:0] wdata, rdata;
   logic [1:0]  pin;
   int          n_errors, comparisons;
   pwmc_top u_pwmc_top (.i_mclk(mclk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
      .o_rdata(rdata), .i_fault_pin(fault), .i_dbg_stall(stall), .o_pwm_pin(pin), .o_irq(irq));
   pwmc_drv_model u_pwmc_drv_model (.i_mclk(mclk), .i_rst_n(rst_n), .i_gate(pin), .i_trip(trip), .i_clr(clr),
      .o_fault(fault), .o_edges(edges));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1 chk(rdata, exp);
      @(posedge mclk);
   endtask
   // Count pin zero rises over 100 cycles
   task automatic edge_chk(input int lo, input int hi);
      repeat (12) @(posedge mclk);
      clr <= 1'b1;
      @(posedge mclk);
      clr <= 1'b0;
      repeat (100) @(posedge mclk);
      chk(32'(edges >= 8'(lo) && edges <= 8'(hi)), 32'h1);
   endtask
   task automatic test_done();
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // Clock at 8 ns
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   // Watchdog well beyond the expected run
   initial begin
      #30000;
      n_errors++;
      test_done();
   end
   // Test sequence
   initial begin
      {rst_n, wr, rd, stall, trip, clr, addr, wdata} = '0;
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      for (int a = 0; a < 'h78; a += 4) rd_chk(8'(a), 32'h0);
      wr_reg(OFS_OUT_EN, 32'hffff_ffff);
      rd_chk(OFS_OUT_EN, 32'h3);
      wr_reg(OFS_DB_RISE, 32'hffff_ffff);
      rd_chk(OFS_DB_RISE, 32'hfff);
      wr_reg(OFS_DB_FALL, 32'h0000_0abc);
      rd_chk(OFS_DB_FALL, 32'habc);
      wr_reg(OFS_MOD_IRQ_RAW, 32'hffff_ffff);
      rd_chk(OFS_MOD_IRQ_RAW, 32'h0);
      $display("registers done");
      wr_reg(OFS_GEN_ACT_A, 32'h8c);
      wr_reg(OFS_GEN_ACT_B, 32'h80c);
      wr_reg(OFS_GEN_CMPA, 32'h2);
      wr_reg(OFS_GEN_CMPB, 32'h1);
      wr_reg(OFS_GEN_LOAD, 32'h9);
      wr_reg(OFS_GEN_CTL, 32'h1);
      edge_chk(9, 11);
      wr_reg(OFS_GEN_LOAD, 32'h4);
      edge_chk(19, 21);
      wr_reg(OFS_GEN_CTL, 32'h19);
      wr_reg(OFS_GEN_LOAD, 32'h9);
      edge_chk(19, 21);
      wr_reg(OFS_MASTER_CTL, 32'h1);
      edge_chk(9, 11);
      rd_chk(OFS_MASTER_CTL, 32'h0);
      wr_reg(OFS_CNT_SYNC, 32'h1);
      repeat (2) @(posedge mclk);
      rd_chk(OFS_CNT_SYNC, 32'h0);
      wr_reg(OFS_GEN_IRQ_EN, 32'h1);
      wr_reg(OFS_MOD_IRQ_EN, 32'h1);
      repeat (12) @(posedge mclk);
      chk(32'(irq), 32'h1);
      $display("generator done");
      wr_reg(OFS_MOD_IRQ_EN, 32'h0001_0000);
      wr_reg(OFS_OUT_INV, 32'h3);
      wr_reg(OFS_OUT_FAULT, 32'h1);
      trip <= 1'b1;
      repeat (8) @(posedge mclk);
      chk(32'(pin[0]), 32'h1);
      chk(32'(irq), 32'h1);
      rd_chk(OFS_FAULT_LVL, 32'h1);
      trip <= 1'b0;
      repeat (8) @(posedge mclk);
      wr_reg(OFS_MOD_IRQ_ISC, 32'h0001_0000);
      rd_chk(OFS_MOD_IRQ_RAW, 32'h1);
      chk(32'(irq), 32'h0);
      $display("fault done");
      wr_reg(OFS_OUT_FAULT, 32'h3);
      wr_reg(OFS_OUT_INV, 32'h0);
      stall <= 1'b1;
      repeat (20) @(posedge mclk);
      chk(32'(pin), 32'h0);
      chk(32'(irq), 32'h0);
      rd_chk(OFS_GEN_COUNT, 32'h0);
      stall <= 1'b0;
      wr_reg(OFS_OUT_EN, 32'h0);
      wr_reg(OFS_OUT_INV, 32'h2);
      repeat (3) @(posedge mclk);
      chk(32'(pin), 32'h2);
      $display("stall and output stage done");
      test_done();
   end
endmodule
`default_nettype wire
